// ### hw/port_diagnostic_engine.v
// port diagnostic engine: error counters, pattern send, parallel send,
// memory test, converter display modes and lamp test
// assumes keypad pulses and uart flags on clk; cts and busy are pins
`timescale 1ns/1ps
`include "port_diag_defines.vh"

module port_diagnostic_engine #(
  parameter [31:0] par_timeout_cycles = `PAR_TIMEOUT_S * `CLK_HZ
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        test_start,
  input  wire [3:0]  test_sel,
  input  wire        key_enter,
  input  wire        key_clear,
  input  wire        key_print,
  input  wire        key_digit_valid,
  input  wire [7:0]  key_digit,
  input  wire [1:0]  rx_char_valid,
  input  wire [1:0]  rx_parity_err,
  input  wire [1:0]  rx_frame_err,
  input  wire [1:0]  cts,
  input  wire [1:0]  tx_ready,
  output wire [1:0]  tx_valid,
  output reg  [7:0]  tx_data,
  output reg  [15:0] tx_count,
  output reg         send_permit_fault_message,
  output reg  [13:0] error_count_readout,
  input  wire        par_busy,
  output reg         par_strobe,
  output reg  [7:0]  par_data,
  output reg  [15:0] par_count,
  output reg  [23:0] par_first3,
  output wire        par_sending,
  output reg  [4:0]  err_code,
  input  wire        mem_we,
  input  wire [4:0]  mem_addr,
  input  wire [7:0]  mem_wdata,
  output reg  [7:0]  mem_rdata,
  output wire        mem_test_running,
  output reg         memory_test_pass_message,
  output reg         mem_test_fail,
  output reg  [4:0]  mem_fail_addr,
  input  wire        adc_valid,
  input  wire [23:0] adc_data,
  output reg  [1:0]  ad_mode,
  output reg  [23:0] ad_display,
  output reg         ad_tx_valid,
  output reg         lamp_all_on,
  output reg  [3:0]  active_test
);

  localparam [4:0] st_idle = 5'b00001;
  localparam [4:0] st_stx  = 5'b00010;
  localparam [4:0] st_ptx  = 5'b00100;
  localparam [4:0] st_mem  = 5'b01000;
  localparam [4:0] st_perr = 5'b10000;

  reg  [4:0]  state;
  reg  [1:0]  cts_meta;
  reg  [1:0]  cts_sync;
  reg         busy_meta;
  reg         busy_sync;
  reg  [3:0]  pat_idx;
  reg  [31:0] par_timer;
  reg  [1:0]  par_gap;
  reg  [2:0]  par_idx;
  reg  [3:0]  buf_len;
  reg  [7:0]  dbuf [0:7];
  reg  [7:0]  ram [0:31];
  reg  [4:0]  t_addr;
  reg  [2:0]  t_phase;
  reg  [7:0]  t_save;
  reg  [23:0] filt;
  reg  [23:0] adc_last;
  reg  [23:0] baseline;

  wire        tx_port = (active_test == `TEST_SER2_TX);
  wire        buf_we;
  wire        arr_we;
  wire [4:0]  arr_addr;
  wire [7:0]  arr_wdata;
  wire [24:0] ad_diff;
  wire [24:0] filt_sum;

  // fixed pattern: digits 1..9, 0, then A..F
  function [7:0] pattern_char;
    input [3:0] i;
    begin
      if (i < `PAT_NINE_IDX)
        pattern_char = `PAT_DIGIT_BASE + {4'h0, i};
      else if (i == `PAT_NINE_IDX)
        pattern_char = `PAT_ZERO;
      else
        pattern_char = `PAT_ALPHA_BASE + {4'h0, i};
    end
  endfunction

  // two-flop synchronisers for pin inputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_meta  <= 2'h0;
      cts_sync  <= 2'h0;
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
    end else begin
      cts_meta  <= cts;
      cts_sync  <= cts_meta;
      busy_meta <= par_busy;
      busy_sync <= busy_meta;
    end
  end

  // per-port receive error counters
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : gen_port
      reg  [6:0] pcnt;
      reg  [6:0] fcnt;
      wire       clr = test_start &&
                       (test_sel == (p ? `TEST_SER2_ERR : `TEST_SER1_ERR));
      wire       ok  = rx_char_valid[p];
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pcnt <= 7'h00;
          fcnt <= 7'h00;
        end else begin
          // a flagged character in the clearing cycle still counts
          if (ok && rx_parity_err[p])
            pcnt <= clr ? 7'h01 :
                    (pcnt == `ERR_MAX) ? pcnt :
                    pcnt + 7'h01;
          else if (clr)
            pcnt <= 7'h00;
          if (ok && rx_frame_err[p])
            fcnt <= clr ? 7'h01 :
                    (fcnt == `ERR_MAX) ? fcnt :
                    fcnt + 7'h01;
          else if (clr)
            fcnt <= 7'h00;
        end
      end
    end
  endgenerate

  // parity count in the upper half, framing in the lower half
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      error_count_readout <= 14'h0000;
    else if (active_test == `TEST_SER2_ERR)
      error_count_readout <= {gen_port[1].pcnt, gen_port[1].fcnt};
    else
      error_count_readout <= {gen_port[0].pcnt, gen_port[0].fcnt};
  end

  assign tx_valid = (state == st_stx) ? {tx_port, ~tx_port} : 2'h0;
  assign par_sending = (state == st_ptx);
  assign mem_test_running = (state == st_mem);
  assign buf_we = key_digit_valid && (state == st_idle) &&
                  (active_test == `TEST_PAR_TX) && (buf_len < `PAR_BUF_MAX);

  // keyed parallel data buffer
  always @(posedge clk) begin
    if (buf_we)
      dbuf[buf_len[2:0]] <= key_digit;
  end

  // memory array, shared by the host port and the test walk
  assign arr_we = mem_test_running ?
                  (t_phase == 3'h1 || t_phase == 3'h3 || t_phase == 3'h5) :
                  mem_we;
  assign arr_addr  = mem_test_running ? t_addr : mem_addr;
  assign arr_wdata = !mem_test_running ? mem_wdata :
                     (t_phase == 3'h1) ? `MEM_PAT_A :
                     (t_phase == 3'h3) ? `MEM_PAT_B : t_save;

  always @(posedge clk) begin
    if (arr_we)
      ram[arr_addr] <= arr_wdata;
    mem_rdata <= ram[mem_addr];
  end

  // test sequencing
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state                     <= st_idle;
      active_test               <= `TEST_NONE;
      pat_idx                   <= 4'h0;
      tx_data                   <= 8'h00;
      tx_count                  <= 16'h0000;
      send_permit_fault_message <= 1'b0;
      par_strobe                <= 1'b0;
      par_data                  <= 8'h00;
      par_count                 <= 16'h0000;
      par_first3                <= 24'h000000;
      par_timer                 <= 32'h00000000;
      par_gap                   <= 2'h0;
      par_idx                   <= 3'h0;
      buf_len                   <= 4'h0;
      err_code                  <= 5'h00;
      t_addr                    <= 5'h00;
      t_phase                   <= 3'h0;
      t_save                    <= 8'h00;
      memory_test_pass_message  <= 1'b0;
      mem_test_fail             <= 1'b0;
      mem_fail_addr             <= 5'h00;
      lamp_all_on               <= 1'b0;
    end else begin
      par_strobe <= 1'b0;
      if (buf_we)
        buf_len <= buf_len + 4'h1;
      if (test_start) begin
        active_test               <= test_sel;
        state                     <= (test_sel == `TEST_MEM) ? st_mem
                                                             : st_idle;
        tx_count                  <= 16'h0000;
        send_permit_fault_message <= 1'b0;
        par_count                 <= 16'h0000;
        buf_len                   <= 4'h0;
        err_code                  <= 5'h00;
        t_addr                    <= 5'h00;
        t_phase                   <= 3'h0;
        memory_test_pass_message  <= 1'b0;
        mem_test_fail             <= 1'b0;
        lamp_all_on               <= (test_sel == `TEST_LAMP);
      end else if (key_clear && state != st_mem) begin
        state    <= st_idle;
        err_code <= 5'h00;
        if (state != st_perr) begin
          active_test <= `TEST_NONE;
          lamp_all_on <= 1'b0;
        end
      end else begin
        case (state)
          st_idle: begin
            if (key_enter && (active_test == `TEST_SER1_TX ||
                              active_test == `TEST_SER2_TX)) begin
              if (!cts_sync[tx_port]) begin
                send_permit_fault_message <= 1'b1;
              end else begin
                send_permit_fault_message <= 1'b0;
                state   <= st_stx;
                pat_idx <= 4'h0;
                tx_data <= pattern_char(4'h0);
              end
            end else if (key_enter && active_test == `TEST_PAR_TX &&
                         buf_len != 4'h0) begin
              state     <= st_ptx;
              par_timer <= 32'h00000000;
              par_gap   <= 2'h0;
              par_idx   <= 3'h0;
            end
          end
          st_stx: begin
            if (tx_ready[tx_port]) begin
              if (pat_idx == `PAT_LAST) begin
                state    <= st_idle;
                tx_count <= tx_count + 16'h0001;
              end else begin
                pat_idx <= pat_idx + 4'h1;
                tx_data <= pattern_char(pat_idx + 4'h1);
              end
            end
          end
          st_ptx: begin
            par_timer <= par_timer + 32'h00000001;
            if (par_timer >= par_timeout_cycles - 32'h00000001) begin
              state    <= st_perr;
              err_code <= `PAR_ERR_CODE;
            end else if (par_gap != 2'h0) begin
              par_gap <= par_gap - 2'h1;
            end else if (!par_strobe && !busy_sync) begin
              par_strobe <= 1'b1;
              par_data   <= dbuf[par_idx];
              par_gap    <= `PAR_GAP;
              par_idx    <= par_idx + 3'h1;
              if ({1'b0, par_idx} == buf_len - 4'h1) begin
                state      <= st_idle;
                par_count  <= par_count + 16'h0001;
                par_first3 <= {dbuf[0], dbuf[1], dbuf[2]};
              end
            end
          end
          st_mem: begin
            t_phase <= t_phase + 3'h1;
            case (t_phase)
              3'h0: t_save <= ram[t_addr];
              3'h2: if (ram[t_addr] != `MEM_PAT_A) begin
                mem_test_fail <= 1'b1;
                mem_fail_addr <= t_addr;
                t_phase       <= 3'h5;
              end
              3'h4: if (ram[t_addr] != `MEM_PAT_B) begin
                mem_test_fail <= 1'b1;
                mem_fail_addr <= t_addr;
              end
              3'h5: begin
                t_phase <= 3'h0;
                if (mem_test_fail || t_addr == `MEM_LAST) begin
                  state                    <= st_idle;
                  memory_test_pass_message <= !mem_test_fail;
                end else begin
                  t_addr <= t_addr + 5'h01;
                end
              end
              default: ;
            endcase
          end
          st_perr: ;
          default: state <= st_idle;
        endcase
      end
    end
  end

  // converter display modes
  assign ad_diff  = {1'b0, adc_data} - {1'b0, filt};
  assign filt_sum = {1'b0, filt} + {{3{ad_diff[24]}}, ad_diff[24:3]};

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ad_mode     <= `AD_FILTERED;
      ad_display  <= 24'h000000;
      ad_tx_valid <= 1'b0;
      filt        <= 24'h000000;
      adc_last    <= 24'h000000;
      baseline    <= 24'h000000;
    end else begin
      ad_tx_valid <= 1'b0;
      if (adc_valid) begin
        adc_last <= adc_data;
        filt     <= filt_sum[23:0];
      end
      if (test_start) begin
        ad_mode <= `AD_FILTERED;
      end else if (active_test == `TEST_AD) begin
        if (key_print)
          ad_mode <= (ad_mode == `AD_DRIFT) ? `AD_FILTERED
                                            : ad_mode + 2'h1;
        if (key_enter && ad_mode == `AD_DRIFT)
          baseline <= adc_last;
        case (ad_mode)
          `AD_FILTERED: ad_display <= filt;
          `AD_RAW_TX: begin
            ad_display  <= adc_last;
            ad_tx_valid <= adc_valid;
          end
          default: ad_display <= adc_last - baseline;
        endcase
      end
    end
  end

endmodule // port_diagnostic_engine

// ### hw/port_diag_defines.vh
// constants for the port diagnostic engine
// assumes a 250 MHz core clock and keypad test numbers 2..10
`ifndef PORT_DIAG_DEFINES_VH
`define PORT_DIAG_DEFINES_VH

// test numbers selected from the keypad
`define TEST_SER1_ERR   4'h2
`define TEST_SER1_TX    4'h3
`define TEST_SER2_ERR   4'h5
`define TEST_SER2_TX    4'h6
`define TEST_PAR_TX     4'h7
`define TEST_AD         4'h8
`define TEST_MEM        4'h9
`define TEST_LAMP       4'ha
`define TEST_NONE       4'h0

// receive error counters
`define ERR_MAX         7'd99

// serial test pattern
`define PAT_LAST        4'hf
`define PAT_DIGIT_BASE  8'h31
`define PAT_ZERO        8'h30
`define PAT_ALPHA_BASE  8'h37
`define PAT_NINE_IDX    4'h9

// parallel port
`define CLK_HZ          32'd250000000
`define PAR_TIMEOUT_S   32'd15
`define PAR_ERR_CODE    5'd13
`define PAR_GAP         2'h3
`define PAR_BUF_MAX     4'h8

// memory test
`define MEM_LAST        5'h1f
`define MEM_PAT_A       8'h55
`define MEM_PAT_B       8'haa

// converter display modes
`define AD_FILTERED     2'h0
`define AD_RAW_TX       2'h1
`define AD_DRIFT        2'h2

`endif

// ### verification/port_diag_asserts.sv
// checker for the port diagnostic engine, sees its ports only
// assumes one clock domain and the async active low reset
`timescale 1ns/1ps
`include "port_diag_defines.vh"
module port_diag_asserts #(
  parameter [31:0] par_timeout_cycles = 32'd50
) (
  input wire        clk,
  input wire        reset_n,
  input wire        test_start,
  input wire [3:0]  test_sel,
  input wire        key_enter,
  input wire        key_print,
  input wire [1:0]  rx_char_valid,
  input wire [1:0]  cts,
  input wire [1:0]  tx_valid,
  input wire [7:0]  tx_data,
  input wire [15:0] tx_count,
  input wire        send_permit_fault_message,
  input wire [13:0] error_count_readout,
  input wire        par_busy,
  input wire        par_strobe,
  input wire [15:0] par_count,
  input wire        par_sending,
  input wire [4:0]  err_code,
  input wire        mem_test_running,
  input wire        memory_test_pass_message,
  input wire        mem_test_fail,
  input wire [1:0]  ad_mode,
  input wire        lamp_all_on,
  input wire [3:0]  active_test
);
  reg [31:0] send_len;
  always @(posedge clk or negedge reset_n)
    if (!reset_n) send_len <= 32'h0;
    else send_len <= par_sending ? send_len + 32'h1 : 32'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_no_cts;
    !cts[0] [*3];
  endsequence
  sequence s_enter1;
    key_enter && !test_start && !tx_valid[0]
      && active_test == `TEST_SER1_TX;
  endsequence

  property p_clear;
    test_start && test_sel == `TEST_SER1_ERR && !rx_char_valid[0]
      |-> ##2 error_count_readout == 14'h0;
  endproperty
  property p_sat;
    error_count_readout[13:7] <= 7'd99 && error_count_readout[6:0] <= 7'd99;
  endproperty
  property p_first;
    $rose(|tx_valid) |-> tx_data == 8'h31;
  endproperty
  property p_txcnt;
    $fell(|tx_valid) |-> tx_count == $past(tx_count) + 16'h1;
  endproperty
  property p_cts;
    s_no_cts ##0 s_enter1 |=> send_permit_fault_message && !tx_valid[0];
  endproperty
  property p_busy;
    par_busy [*4] |-> !par_strobe;
  endproperty
  property p_tmo;
    send_len <= par_timeout_cycles + 32'd4;
  endproperty
  property p_err;
    $changed(err_code) && err_code != 5'h0
      |-> err_code == `PAR_ERR_CODE && $past(par_sending);
  endproperty
  property p_pcnt;
    $changed(par_count) && !$past(test_start)
      |-> par_count == $past(par_count) + 16'h1 && par_strobe;
  endproperty
  property p_mem;
    $fell(mem_test_running) |-> memory_test_pass_message != mem_test_fail;
  endproperty
  property p_mode;
    key_print && !test_start && active_test == `TEST_AD
      |=> ad_mode == ($past(ad_mode) == 2'h2 ? 2'h0 : $past(ad_mode) + 2'h1);
  endproperty
  property p_lamp;
    active_test == `TEST_LAMP && $past(active_test) == `TEST_LAMP
      |-> lamp_all_on;
  endproperty

  a_clear: assert property (p_clear) else $error("count not cleared");
  a_sat: assert property (p_sat) else $error("count above max");
  a_first: assert property (p_first) else $error("bad first char");
  a_txcnt: assert property (p_txcnt) else $error("send count");
  a_cts: assert property (p_cts) else $error("send without cts");
  a_busy: assert property (p_busy) else $error("strobe while busy");
  a_tmo: assert property (p_tmo) else $error("send too long");
  a_err: assert property (p_err) else $error("bad error code");
  a_pcnt: assert property (p_pcnt) else $error("par count step");
  a_mem: assert property (p_mem) else $error("no mem verdict");
  a_mode: assert property (p_mode) else $error("mode order");
  a_lamp: assert property (p_lamp) else $error("lamps off");
endmodule // port_diag_asserts

bind port_diagnostic_engine port_diag_asserts #(
  .par_timeout_cycles(par_timeout_cycles)
) u_chk (.*);

// ### verification/port_diag_partner.sv
// far side model: slow serial sink, printer busy, cts jumper
// assumes the bench steers cts_on and stuck
`timescale 1ns/1ps
module port_diag_partner (
  input  wire       clk,
  input  wire [1:0] cts_on,
  input  wire       stuck,
  input  wire [1:0] tx_valid,
  input  wire [7:0] tx_data,
  input  wire       par_strobe,
  input  wire [7:0] par_data,
  output reg  [1:0] tx_ready,
  output wire [1:0] cts,
  output reg        par_busy
);
  reg [7:0] rx_buf [0:15];
  integer   rx_n = 0;
  reg [2:0] hold = 3'h0;
  assign cts = cts_on;
  initial tx_ready = 2'h0;
  initial par_busy = 1'b0;
  // records every character taken from either port
  always @(posedge clk) begin
    if (|(tx_valid & tx_ready) || par_strobe) begin
      rx_buf[rx_n % 16] <= par_strobe ? par_data : tx_data;
      rx_n <= rx_n + 1;
    end
  end
  always @(negedge clk) begin
    tx_ready <= tx_valid & ~tx_ready;
    if (par_strobe) hold <= 3'h4;
    else if (hold != 3'h0) hold <= hold - 3'h1;
    par_busy <= stuck | par_strobe | (hold != 3'h0);
  end
endmodule // port_diag_partner

// ### verification/tb.sv
// testbench for the port diagnostic engine
// assumes the partner model and a short parallel timeout
`timescale 1ns/1ps
`include "port_diag_defines.vh"
module tb;
  logic        clk = 0, reset_n = 0, test_start = 0, key_enter = 0;
  logic        key_clear = 0, key_print = 0, key_digit_valid = 0;
  logic        mem_we = 0, adc_valid = 0, stuck = 0;
  logic [3:0]  test_sel = 4'h0;
  logic [7:0]  key_digit = 8'h0, mem_wdata = 8'h0;
  logic [4:0]  mem_addr = 5'h0;
  logic [1:0]  rx_char_valid = 0, rx_parity_err = 0, rx_frame_err = 0;
  logic [1:0]  cts_on = 2'h0;
  logic [23:0] adc_data = 24'h012345;
  wire [1:0]   tx_ready, cts, tx_valid, ad_mode;
  wire         par_busy, send_permit_fault_message, par_strobe;
  wire         par_sending, mem_test_running, memory_test_pass_message;
  wire         mem_test_fail, ad_tx_valid, lamp_all_on;
  wire [7:0]   tx_data, par_data, mem_rdata;
  wire [15:0]  tx_count, par_count;
  wire [13:0]  error_count_readout;
  wire [23:0]  par_first3, ad_display;
  wire [4:0]   err_code, mem_fail_addr;
  wire [3:0]   active_test;
  integer      errors = 0, compares = 0, n0, i, j;

  port_diagnostic_engine #(.par_timeout_cycles(32'd200)) uut (.*);
  port_diag_partner pm (.*);
  always #2 clk = ~clk;

  task chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task start(input [3:0] s);
    @(negedge clk) {test_start, test_sel} = {1'b1, s};
    @(negedge clk) test_start = 0;
  endtask
  task press(input [2:0] k);
    @(negedge clk) {key_print, key_clear, key_enter} = k;
    @(negedge clk) {key_print, key_clear, key_enter} = 3'h0;
  endtask
  task rxe(input [1:0] v, p, f);
    @(negedge clk) {rx_char_valid, rx_parity_err, rx_frame_err} = {v, p, f};
    @(negedge clk) {rx_char_valid, rx_parity_err, rx_frame_err} = 6'h0;
  endtask
  localparam [127:0] pattern = "1234567890ABCDEF";
  function [7:0] pat(input integer k);
    pat = pattern[8 * (15 - k) +: 8];
  endfunction

  task t_err;
    start(`TEST_SER1_ERR);
    rxe(2'h1, 2'h1, 2'h0);
    rxe(2'h1, 2'h0, 2'h1);
    rxe(2'h3, 2'h3, 2'h3);
    rxe(2'h1, 2'h0, 2'h0);
    wt(2);
    chk("pf", error_count_readout, {7'd2, 7'd2});
    repeat (101) rxe(2'h1, 2'h1, 2'h0);
    wt(2);
    chk("sat", error_count_readout, {7'd99, 7'd2});
    start(`TEST_SER2_ERR);
    rxe(2'h2, 2'h0, 2'h2);
    rxe(2'h1, 2'h1, 2'h1);
    wt(2);
    chk("p2", error_count_readout, {7'd0, 7'd1});
    start(`TEST_SER1_ERR);
    wt(2);
    chk("clr", error_count_readout, 0);
  endtask

  task t_ser(input integer p);
    cts_on = 2'h0;
    start(p ? `TEST_SER2_TX : `TEST_SER1_TX);
    chk("txcnt", tx_count, 0);
    press(3'h1);
    wt(1);
    chk("fault", send_permit_fault_message, 1);
    chk("txv", tx_valid, 0);
    cts_on[p] = 1'b1;
    wt(3);
    for (j = 1; j < 3; j++) begin
      n0 = pm.rx_n;
      press(3'h1);
      for (i = 0; i < 99 && tx_valid !== 2'h0; i++) wt(1);
      chk("txdone", tx_valid, 0);
      for (i = 0; i < 16; i++) chk("ch", pm.rx_buf[(n0 + i) % 16], pat(i));
      chk("txcnt", tx_count, j);
    end
  endtask

  task t_par;
    start(`TEST_PAR_TX);
    stuck = 1;
    for (i = 0; i < 4; i++)
      @(negedge clk) {key_digit_valid, key_digit} = {1'b1, 8'h35 + 8'(i)};
    @(negedge clk) key_digit_valid = 0;
    n0 = pm.rx_n;
    press(3'h1);
    wt(20);
    chk("held", pm.rx_n, n0);
    stuck = 0;
    for (i = 0; i < 150 && par_sending !== 1'b0; i++) wt(1);
    chk("pdone", par_sending, 0);
    wt(1);
    for (i = 0; i < 4; i++) chk("pch", pm.rx_buf[(n0 + i) % 16], 8'h35 + i);
    chk("pcnt", par_count, 1);
    chk("first3", par_first3, 24'h353637);
    stuck = 1;
    wt(3);
    n0 = pm.rx_n;
    press(3'h1);
    wt(220);
    chk("held2", pm.rx_n, n0);
    chk("e13", err_code, 13);
    chk("pcnt", par_count, 1);
    stuck = 0;
    press(3'h2);
    wt(1);
    chk("e0", err_code, 0);
  endtask

  task t_mem;
    for (i = 0; i < 32; i++)
      @(negedge clk) {mem_we, mem_addr, mem_wdata} = {1'b1, 5'(i), 8'hc0 ^ 8'(i)};
    @(negedge clk) mem_we = 0;
    start(`TEST_MEM);
    for (i = 0; i < 300 && mem_test_running !== 1'b0; i++) wt(1);
    chk("mdone", mem_test_running, 0);
    chk("pass", memory_test_pass_message, 1);
    chk("fail", mem_test_fail, 0);
    chk("faddr", mem_fail_addr, 0);
    for (i = 0; i < 32; i++) begin
      @(negedge clk) mem_addr = 5'(i);
      @(negedge clk) chk("keep", mem_rdata, 8'hc0 ^ i);
    end
  endtask

  task t_misc;
    start(`TEST_AD);
    chk("mode", ad_mode, 0);
    for (i = 1; i < 4; i++) begin
      press(3'h4);
      chk("mode", ad_mode, i % 3);
    end
    press(3'h4);
    @(negedge clk) adc_valid = 1;
    @(negedge clk) adc_valid = 0;
    chk("adtx", ad_tx_valid, 1);
    press(3'h4);
    @(negedge clk) adc_valid = 1;
    @(negedge clk) adc_valid = 0;
    press(3'h1);
    wt(1);
    chk("drift", ad_display, 0);
    start(`TEST_LAMP);
    wt(1);
    chk("lamp", lamp_all_on, 1);
    chk("lampsel", active_test, `TEST_LAMP);
    press(3'h2);
    wt(1);
    chk("lamp", lamp_all_on, 0);
    chk("exit", active_test, `TEST_NONE);
  endtask

  task finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    wt(10);
    reset_n = 1;
    wt(3);
    t_err;
    t_ser(0);
    t_ser(1);
    t_par;
    t_mem;
    t_misc;
    finish_test;
  end
  initial begin
    #100000;
    errors++;
    finish_test;
  end
endmodule // tb
